// ==== design/slg_pkg.sv ====
package slg_pkg;
  // Data path widths
  localparam int SLG_DW = 16;
  localparam int SLG_PCW = 23;
  // Fixed lower bound of the stack, below it lies the special register space
  localparam logic [15:0] SLG_STACK_FLOOR = 16'h0800;
  // Word step of the stack pointer
  localparam logic [15:0] SLG_WORD_STEP = 16'h0002;
  // Bit zero of pointer and limit is forced low
  localparam logic [15:0] SLG_ALIGN_MASK = 16'hfffe;
  // Pointer value after reset
  localparam logic [15:0] SLG_SP_RESET = 16'h0800;
  // Stack operation codes
  typedef enum logic [1:0] {
    SLG_OP_NONE = 2'h0,
    SLG_OP_PUSH = 2'h1,
    SLG_OP_POP = 2'h2,
    SLG_OP_INDIRECT = 2'h3
  } slg_op_t;
  // Push source selection
  typedef enum logic [1:0] {
    SLG_SRC_DATA = 2'h0,
    SLG_SRC_PC_CALL_LO = 2'h1,
    SLG_SRC_PC_HI_CALL = 2'h2,
    SLG_SRC_PC_HI_EXC = 2'h3
  } slg_src_t;
endpackage

// ==== design/slg_ram_gate.sv ====
`timescale 1ns/1ps
// Checks one data access against both secure RAM segments
module slg_ram_gate (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Access
  input wire logic access_in,
  input wire logic [15:0] addr_in,
  // Segment windows and enables
  input wire logic boot_secure_ram_segment_en_in,
  input wire logic [15:0] boot_secure_ram_segment_lo_in,
  input wire logic [15:0] boot_secure_ram_segment_hi_in,
  input wire logic secure_ram_segment_en_in,
  input wire logic [15:0] secure_ram_segment_lo_in,
  input wire logic [15:0] secure_ram_segment_hi_in,
  // Execution origin
  input wire logic exec_boot_flash_in,
  input wire logic exec_secure_flash_in,
  // Verdict
  output logic allow_out,
  output logic violation_out
);
  wire in_boot_seg;
  wire in_sec_seg;
  wire boot_deny;
  wire sec_deny;

  // Range decode; bounds are inclusive
  assign in_boot_seg = boot_secure_ram_segment_en_in && (addr_in >= boot_secure_ram_segment_lo_in)
                       && (addr_in <= boot_secure_ram_segment_hi_in);
  assign in_sec_seg = secure_ram_segment_en_in && (addr_in >= secure_ram_segment_lo_in)
                      && (addr_in <= secure_ram_segment_hi_in);
  assign boot_deny = in_boot_seg && !exec_boot_flash_in;
  assign sec_deny = in_sec_seg && !exec_secure_flash_in;
  // Allow is combinational so the core can squash the access in the same cycle
  assign allow_out = !(boot_deny || sec_deny);

  // Registered violation pulse for exception logic
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      violation_out <= 1'b0;
    end else begin
      violation_out <= access_in && (boot_deny || sec_deny);
    end
  end

  property p_boot_gate;
    @(posedge clk_in) disable iff (rst_in)
      (access_in && boot_secure_ram_segment_en_in && !exec_boot_flash_in
       && (addr_in >= boot_secure_ram_segment_lo_in) && (addr_in <= boot_secure_ram_segment_hi_in))
        |-> !allow_out ##1 violation_out;
  endproperty
  a_boot_gate: assert property (p_boot_gate) else $error("boot segment access allowed");

  property p_sec_gate;
    @(posedge clk_in) disable iff (rst_in)
      (access_in && secure_ram_segment_en_in && !exec_secure_flash_in
       && (addr_in >= secure_ram_segment_lo_in) && (addr_in <= secure_ram_segment_hi_in))
        |-> !allow_out ##1 violation_out;
  endproperty
  a_sec_gate: assert property (p_sec_gate) else $error("secure segment violation missed");
endmodule // slg_ram_gate

// ==== design/slg_stack_guard.sv ====
`timescale 1ns/1ps
module slg_stack_guard
  import slg_pkg::*;
#(
  parameter int DW = slg_pkg::SLG_DW
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Stack operation request from the core
  input wire slg_pkg::slg_op_t op_in,
  input wire slg_pkg::slg_src_t src_in,
  input wire logic [15:0] push_data_in,
  input wire logic [15:0] indirect_ea_in,
  // Program counter and status
  input wire logic [22:0] pc_in,
  input wire logic [7:0] status_low_byte_in,
  // Pointer and limit writes
  input wire logic sp_wr_in,
  input wire logic [15:0] sp_wdata_in,
  input wire logic limit_wr_in,
  input wire logic [15:0] limit_wdata_in,
  // Secure RAM segments
  input wire logic boot_secure_ram_segment_en_in,
  input wire logic [15:0] boot_secure_ram_segment_lo_in,
  input wire logic [15:0] boot_secure_ram_segment_hi_in,
  input wire logic secure_ram_segment_en_in,
  input wire logic [15:0] secure_ram_segment_lo_in,
  input wire logic [15:0] secure_ram_segment_hi_in,
  input wire logic exec_boot_flash_in,
  input wire logic exec_secure_flash_in,
  // Memory access toward data RAM
  output logic mem_valid_out,
  output logic mem_write_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  output logic mem_allow_out,
  // State and traps
  output logic [15:0] stack_pointer_register_out,
  output logic [15:0] stack_limit_register_out,
  output logic stack_error_trap_out,
  output logic ram_violation_trap_out
);
  initial begin
    if (DW != 16) begin
      $error("slg_stack_guard supports a 16-bit data width only");
    end
  end

  logic [15:0] stack_pointer_register;
  logic [15:0] stack_limit_register;
  logic [15:0] next_sp;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic mem_valid;
  logic mem_write;
  logic stack_error_trap;

  wire is_push;
  wire is_pop;
  wire is_ind;
  wire [15:0] sp_dec;
  wire [15:0] sp_inc;
  wire [15:0] ea;
  wire overflow_hit;
  wire underflow_hit;
  wire [15:0] pc_hi_call;
  wire [15:0] pc_hi_exc;
  wire [15:0] push_word;
  wire access_any;
  wire gate_allow;

  // Operation decode
  assign is_push = (op_in == SLG_OP_PUSH);
  assign is_pop = (op_in == SLG_OP_POP);
  assign is_ind = (op_in == SLG_OP_INDIRECT);

  // Pop addresses the word below, push the free word itself
  assign sp_dec = stack_pointer_register - SLG_WORD_STEP;
  assign sp_inc = stack_pointer_register + SLG_WORD_STEP;
  assign ea = is_pop ? sp_dec : (is_push ? stack_pointer_register
                                         : (indirect_ea_in & SLG_ALIGN_MASK));

  // Limit compare on push addresses only; equal is still legal
  assign overflow_hit = is_push && (ea > stack_limit_register);
  // Floor check on every pointer access; a pop near zero would wrap, so the pointer is tested too
  assign underflow_hit = access_any && ((ea < SLG_STACK_FLOOR)
                         || (is_pop && (stack_pointer_register < SLG_STACK_FLOOR + SLG_WORD_STEP)));

  // Program counter word forms and push word select
  assign pc_hi_call = {9'h000, pc_in[22:16]};
  assign pc_hi_exc = {status_low_byte_in, 1'b0, pc_in[22:16]};
  assign push_word = (src_in == SLG_SRC_PC_CALL_LO) ? {pc_in[15:1], 1'b0} :
                     (src_in == SLG_SRC_PC_HI_CALL) ? pc_hi_call :
                     (src_in == SLG_SRC_PC_HI_EXC) ? pc_hi_exc : push_data_in;

  assign access_any = (op_in != SLG_OP_NONE);

  // Secure segment gating of the stack access
  slg_ram_gate u_gate (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .access_in(access_any),
    .addr_in(ea),
    .boot_secure_ram_segment_en_in(boot_secure_ram_segment_en_in),
    .boot_secure_ram_segment_lo_in(boot_secure_ram_segment_lo_in),
    .boot_secure_ram_segment_hi_in(boot_secure_ram_segment_hi_in),
    .secure_ram_segment_en_in(secure_ram_segment_en_in),
    .secure_ram_segment_lo_in(secure_ram_segment_lo_in),
    .secure_ram_segment_hi_in(secure_ram_segment_hi_in),
    .exec_boot_flash_in(exec_boot_flash_in),
    .exec_secure_flash_in(exec_secure_flash_in),
    .allow_out(gate_allow),
    .violation_out(ram_violation_trap_out)
  );

  // Pointer next value; a faulting push or pop leaves the pointer alone
  always_comb begin
    next_sp = stack_pointer_register;
    if (sp_wr_in) begin
      next_sp = sp_wdata_in & SLG_ALIGN_MASK;
    end else if (is_push && !overflow_hit && !underflow_hit) begin
      next_sp = sp_inc;
    end else if (is_pop && !underflow_hit) begin
      next_sp = sp_dec;
    end
  end

  // Memory request toward data RAM
  always_comb begin
    mem_valid = access_any && !overflow_hit && !underflow_hit;
    mem_write = is_push;
    mem_addr = ea;
    mem_wdata = push_word;
  end

  // Pointer and trap registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stack_pointer_register <= SLG_SP_RESET;
      stack_error_trap <= 1'b0;
    end else begin
      stack_pointer_register <= next_sp;
      stack_error_trap <= overflow_hit || underflow_hit;
    end
  end

  // Limit has no reset on purpose: software must load it before relying on it
  always_ff @(posedge clk_in) begin
    if (limit_wr_in) begin
      stack_limit_register <= limit_wdata_in & SLG_ALIGN_MASK;
    end
  end

  // Registered memory outputs; one cycle behind the request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_valid_out <= 1'b0;
      mem_write_out <= 1'b0;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 16'h0000;
      mem_allow_out <= 1'b0;
    end else begin
      mem_valid_out <= mem_valid;
      mem_write_out <= mem_write;
      mem_addr_out <= mem_addr;
      mem_wdata_out <= mem_wdata;
      mem_allow_out <= gate_allow;
    end
  end

  assign stack_pointer_register_out = stack_pointer_register;
  assign stack_limit_register_out = stack_limit_register;
  assign stack_error_trap_out = stack_error_trap;

  property p_push_inc;
    @(posedge clk_in) disable iff (rst_in)
      (is_push && !sp_wr_in && !overflow_hit && !underflow_hit) |=>
        (stack_pointer_register == $past(stack_pointer_register) + SLG_WORD_STEP);
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not advance pointer");

  property p_pop_addr;
    @(posedge clk_in) disable iff (rst_in)
      (is_pop && !underflow_hit) |=> (mem_addr_out == $past(stack_pointer_register) - SLG_WORD_STEP);
  endproperty
  a_pop_addr: assert property (p_pop_addr) else $error("pop address not predecremented");

  property p_push_addr;
    @(posedge clk_in) disable iff (rst_in)
      (is_push && !overflow_hit) |=> (mem_addr_out == $past(stack_pointer_register)) && mem_write_out;
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push not at free word");

  property p_call_msb;
    @(posedge clk_in) disable iff (rst_in)
      (is_push && src_in == SLG_SRC_PC_HI_CALL) |=> !mem_wdata_out[15];
  endproperty
  a_call_msb: assert property (p_call_msb) else $error("call push top bit set");

  property p_exc_srl;
    @(posedge clk_in) disable iff (rst_in)
      (is_push && src_in == SLG_SRC_PC_HI_EXC) |=> (mem_wdata_out[15:8] == $past(status_low_byte_in));
  endproperty
  a_exc_srl: assert property (p_exc_srl) else $error("exception push lacks status byte");

  property p_align;
    @(posedge clk_in) disable iff (rst_in)
      !stack_pointer_register[0];
  endproperty
  a_align: assert property (p_align) else $error("pointer misaligned");

  property p_equal_ok;
    @(posedge clk_in) disable iff (rst_in)
      (is_push && stack_pointer_register == stack_limit_register && stack_pointer_register >= SLG_STACK_FLOOR)
        |=> !stack_error_trap_out;
  endproperty
  a_equal_ok: assert property (p_equal_ok) else $error("trap at pointer equal to limit");

  property p_over_trap;
    @(posedge clk_in) disable iff (rst_in)
      (is_push && stack_pointer_register > stack_limit_register) |=> stack_error_trap_out;
  endproperty
  a_over_trap: assert property (p_over_trap) else $error("overflow trap missed");

  property p_under_trap;
    @(posedge clk_in) disable iff (rst_in)
      (is_pop && stack_pointer_register < SLG_STACK_FLOOR + SLG_WORD_STEP) |=> stack_error_trap_out;
  endproperty
  a_under_trap: assert property (p_under_trap) else $error("underflow trap missed");

  property p_trap_pulse;
    @(posedge clk_in) disable iff (rst_in)
      (stack_error_trap_out && $past(op_in) == SLG_OP_NONE) |-> 1'b0;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap without stack access");

  property p_pop_dec;
    @(posedge clk_in) disable iff (rst_in)
      (is_pop && !sp_wr_in && stack_pointer_register >= SLG_STACK_FLOOR + SLG_WORD_STEP) |=>
        (stack_pointer_register == $past(stack_pointer_register) - SLG_WORD_STEP);
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not lower pointer");

  property p_fault_hold;
    @(posedge clk_in) disable iff (rst_in)
      ((overflow_hit || underflow_hit) && !sp_wr_in) |=>
        (stack_pointer_register == $past(stack_pointer_register)) && !mem_valid_out;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("faulting access moved pointer");

  property p_sp_load;
    @(posedge clk_in) disable iff (rst_in)
      sp_wr_in |=> (stack_pointer_register == ($past(sp_wdata_in) & SLG_ALIGN_MASK));
  endproperty
  a_sp_load: assert property (p_sp_load) else $error("pointer load wrong");

  property p_limit_load;
    @(posedge clk_in) disable iff (rst_in)
      limit_wr_in |=> (stack_limit_register == ($past(limit_wdata_in) & SLG_ALIGN_MASK));
  endproperty
  a_limit_load: assert property (p_limit_load) else $error("limit load wrong");

  property p_push_data;
    @(posedge clk_in) disable iff (rst_in)
      (is_push && src_in == SLG_SRC_DATA) |=> (mem_wdata_out == $past(push_data_in));
  endproperty
  a_push_data: assert property (p_push_data) else $error("pushed word differs");

  property p_call_hi;
    @(posedge clk_in) disable iff (rst_in)
      (is_push && src_in == SLG_SRC_PC_HI_CALL) |=> (mem_wdata_out[15:7] == 9'h000);
  endproperty
  a_call_hi: assert property (p_call_hi) else $error("call upper word not zero extended");

  property p_idle_quiet;
    @(posedge clk_in) disable iff (rst_in)
      (op_in == SLG_OP_NONE) |=> !mem_valid_out && !stack_error_trap_out && !ram_violation_trap_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity without stack access");

  property p_ind_floor;
    @(posedge clk_in) disable iff (rst_in)
      (is_ind && ((indirect_ea_in & SLG_ALIGN_MASK) < SLG_STACK_FLOOR)) |=> stack_error_trap_out && !mem_valid_out;
  endproperty
  a_ind_floor: assert property (p_ind_floor) else $error("indirect below floor not trapped");

  property p_read_only;
    @(posedge clk_in) disable iff (rst_in)
      (is_pop || is_ind) |=> !mem_write_out;
  endproperty
  a_read_only: assert property (p_read_only) else $error("read issued as write");
endmodule // slg_stack_guard

// ==== sim/slg_core_model.sv ====
`timescale 1ns/1ps
// Stand-in for the exception logic of the core behind the guard
module slg_core_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Trap requests from the guard
  input wire logic stack_error_trap_in,
  input wire logic ram_violation_trap_in,
  // Tallies of taken requests
  output logic [15:0] stack_traps_out,
  output logic [15:0] ram_denials_out
);
  // Requests are one-cycle pulses, so a stuck level overcounts and shows up
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stack_traps_out <= 16'h0000;
      ram_denials_out <= 16'h0000;
    end else begin
      stack_traps_out <= stack_traps_out + {15'h0000, stack_error_trap_in};
      ram_denials_out <= ram_denials_out + {15'h0000, ram_violation_trap_in};
    end
  end
endmodule // slg_core_model

// ==== sim/slg_stack_guard_test.sv ====
`timescale 1ns/1ps
module slg_stack_guard_test;
  import slg_pkg::*;
  logic clk_in, rst_in, sp_wr, limit_wr, bs_en, ss_en, exec_bf, exec_sf;
  logic mem_valid, mem_write, mem_allow, trap, viol;
  slg_op_t op;
  slg_src_t src;
  logic [22:0] pc;
  logic [7:0] slb;
  logic [15:0] ea, sp_wdata, limit_wdata, mem_addr, mem_wdata, sp, limit, n_traps, n_denials;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  slg_stack_guard dut_u (.clk_in(clk_in), .rst_in(rst_in), .op_in(op), .src_in(src), .push_data_in(ea),
    .indirect_ea_in(ea), .pc_in(pc), .status_low_byte_in(slb), .sp_wr_in(sp_wr), .sp_wdata_in(sp_wdata),
    .limit_wr_in(limit_wr), .limit_wdata_in(limit_wdata), .boot_secure_ram_segment_en_in(bs_en),
    .boot_secure_ram_segment_lo_in(16'h0900), .boot_secure_ram_segment_hi_in(16'h09ff),
    .secure_ram_segment_en_in(ss_en), .secure_ram_segment_lo_in(16'h0a00),
    .secure_ram_segment_hi_in(16'h0aff), .exec_boot_flash_in(exec_bf), .exec_secure_flash_in(exec_sf),
    .mem_valid_out(mem_valid), .mem_write_out(mem_write), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .mem_allow_out(mem_allow), .stack_pointer_register_out(sp),
    .stack_limit_register_out(limit), .stack_error_trap_out(trap), .ram_violation_trap_out(viol));
  slg_core_model model_u (.clk_in(clk_in), .rst_in(rst_in), .stack_error_trap_in(trap),
    .ram_violation_trap_in(viol), .stack_traps_out(n_traps), .ram_denials_out(n_denials));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Hang guard, well above the roughly 50 cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One op for one cycle; results are settled at the following falling edge
  task automatic do_op(input slg_op_t o, input slg_src_t s, input logic [15:0] d);
    @(negedge clk_in);
    op = o;
    src = s;
    ea = d;
    @(negedge clk_in);
    op = SLG_OP_NONE;
  endtask
  task automatic load(input logic [15:0] s, input logic [15:0] l);
    @(negedge clk_in);
    sp_wr = 1'b1;
    sp_wdata = s;
    limit_wr = 1'b1;
    limit_wdata = l;
    @(negedge clk_in);
    sp_wr = 1'b0;
    limit_wr = 1'b0;
  endtask
  task automatic t_push_limit();
    load(16'h0801, 16'h0807);
    chk(sp, 16'h0800);
    chk(limit, 16'h0806);
    // A push, not an indirect read, follows the limit write
    for (int i = 0; i < 4; i++) begin
      do_op(SLG_OP_PUSH, SLG_SRC_DATA, 16'ha000 + 16'(i));
      chk({14'h0000, mem_valid, mem_write}, 16'h0003);
      chk(mem_addr, 16'h0800 + 16'(2 * i));
      chk(mem_wdata, 16'ha000 + 16'(i));
      chk({15'h0000, trap}, 16'h0000);
      chk(sp, 16'h0802 + 16'(2 * i));
    end
    do_op(SLG_OP_PUSH, SLG_SRC_DATA, 16'hbeef);
    chk({14'h0000, trap, mem_valid}, 16'h0002);
    chk(sp, 16'h0808);
    @(negedge clk_in);
    chk({15'h0000, trap}, 16'h0000);
    do_op(SLG_OP_POP, SLG_SRC_DATA, 16'h0000);
    chk({14'h0000, mem_valid, mem_write}, 16'h0002);
    chk(mem_addr, 16'h0806);
    chk(sp, 16'h0806);
  endtask
  task automatic t_pc_push();
    load(16'h0a00, 16'h0ffe);
    pc = 23'h7abcde;
    slb = 8'h5a;
    do_op(SLG_OP_PUSH, SLG_SRC_PC_CALL_LO, 16'h0000);
    chk(mem_wdata, 16'hbcde);
    do_op(SLG_OP_PUSH, SLG_SRC_PC_HI_CALL, 16'h0000);
    chk(mem_wdata, 16'h007a);
    do_op(SLG_OP_PUSH, SLG_SRC_PC_HI_EXC, 16'h0000);
    chk(mem_wdata, 16'h5a7a);
    chk(sp, 16'h0a06);
  endtask
  task automatic t_underflow();
    load(16'h0800, 16'h0ffe);
    do_op(SLG_OP_POP, SLG_SRC_DATA, 16'h0000);
    chk({14'h0000, trap, mem_valid}, 16'h0002);
    chk(sp, 16'h0800);
    do_op(SLG_OP_INDIRECT, SLG_SRC_DATA, 16'h07f0);
    chk({14'h0000, trap, mem_valid}, 16'h0002);
    do_op(SLG_OP_INDIRECT, SLG_SRC_DATA, 16'h0800);
    chk({14'h0000, trap, mem_valid}, 16'h0001);
    // Pointer below the floor: a pop must not wrap past zero, a push must not advance
    load(16'h0000, 16'h0ffe);
    do_op(SLG_OP_POP, SLG_SRC_DATA, 16'h0000);
    chk({14'h0000, trap, mem_valid}, 16'h0002);
    do_op(SLG_OP_PUSH, SLG_SRC_DATA, 16'h1234);
    chk({14'h0000, trap, mem_valid}, 16'h0002);
    chk(sp, 16'h0000);
  endtask
  // Each segment tried from foreign code and from its own flash
  task automatic t_gate();
    logic [15:0] a;
    bs_en = 1'b1;
    ss_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = i[1] ? 16'h0a00 : 16'h0900;
      exec_bf = ~i[1] & i[0];
      exec_sf = i[1] & i[0];
      do_op(SLG_OP_INDIRECT, SLG_SRC_DATA, a);
      chk({14'h0000, mem_allow, viol}, i[0] ? 16'h0002 : 16'h0001);
    end
    chk(n_denials, 16'h0002);
    chk(n_traps, 16'h0005);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_in = 1'b1;
    op = SLG_OP_NONE;
    src = SLG_SRC_DATA;
    {sp_wr, limit_wr, bs_en, ss_en, exec_bf, exec_sf} = 6'h00;
    {ea, sp_wdata, limit_wdata} = 48'h0;
    pc = 23'h000000;
    slb = 8'h00;
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    chk(sp, 16'h0800);
    chk({15'h0000, mem_valid}, 16'h0000);
    t_push_limit();
    t_pc_push();
    t_underflow();
    t_gate();
    complete_run();
  end
endmodule // slg_stack_guard_test
